// ### hdl/afbp_pkg.sv
// constants and carrier types for the strobe-driven parallel port
// assumes one channel per instance and a 10 MHz core clock
package afbp_pkg;

  // data bus width
  localparam int DW = 8;

  // channel modes, as set by the configuration memory
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_FIFO = 2'h1;
  localparam logic [1:0] MODE_BB_ASYNC = 2'h2;
  localparam logic [1:0] MODE_BB_SYNC = 2'h3;

  // reset and drive values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] OE_NONE = 8'h00;
  localparam logic [7:0] OE_ALL = 8'hff;

  // clock rate
  localparam int CLK_HZ = 10000000;

  // read strobe handling
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_HOLD = 2'b10
  } afbp_rd_state_t;

  // one byte with its valid flag
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } afbp_byte_t;

endpackage : afbp_pkg

// ### hdl/afbp_port.sv
// one channel of the parallel port: strobe-driven FIFO mode and bit-bang mode
// assumes pins arrive asynchronously; the USB side shares clk_i;
// pull-ups on the flag pins are outside the design
`timescale 1ns/1ps

module afbp_port (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // configuration
  input wire logic [1:0] cfg_mode_i,
  input wire logic cfg_wake_en_i,
  // usb engine side
  input wire logic usb_suspend_i,
  input wire afbp_pkg::afbp_byte_t rx_i,
  output logic rx_ready_o,
  output afbp_pkg::afbp_byte_t tx_o,
  input wire logic tx_ready_i,
  output logic send_now_o,
  output logic resume_req_o,
  // bit-bang host side
  input wire logic [7:0] bb_dir_i,
  input wire afbp_pkg::afbp_byte_t bb_wr_i,
  input wire logic bb_rd_req_i,
  output afbp_pkg::afbp_byte_t bb_rd_o,
  // pins
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic send_now_wakeup_n_i,
  input wire logic [7:0] port_data_i,
  output logic [7:0] port_data_o,
  output logic [7:0] port_data_oe_o,
  output logic rx_avail_n_o,
  output logic rx_avail_n_oe_o,
  output logic tx_space_n_o,
  output logic tx_space_n_oe_o,
  output logic write_done_strobe_n_o,
  output logic read_done_strobe_n_o
);

  // pin synchronisers
  logic rd_m, rd_s, rd_d;
  logic wr_m, wr_s, wr_d;
  logic wake_m, wake_s, wake_d;
  logic [7:0] dat_m, dat_s;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_m <= 1'b1;
      rd_s <= 1'b1;
      rd_d <= 1'b1;
      wr_m <= 1'b1;
      wr_s <= 1'b1;
      wr_d <= 1'b1;
      wake_m <= 1'b1;
      wake_s <= 1'b1;
      wake_d <= 1'b1;
      dat_m <= afbp_pkg::DATA_RST;
      dat_s <= afbp_pkg::DATA_RST;
    end else if (ce_i) begin
      rd_m <= rd_n_i;
      rd_s <= rd_m;
      rd_d <= rd_s;
      wr_m <= wr_n_i;
      wr_s <= wr_m;
      wr_d <= wr_s;
      wake_m <= send_now_wakeup_n_i;
      wake_s <= wake_m;
      wake_d <= wake_s;
      dat_m <= port_data_i;
      dat_s <= dat_m;
    end
  end

  logic rd_fall;
  logic wr_fall;
  logic wake_fall;
  assign rd_fall = rd_d & ~rd_s;
  assign wr_fall = wr_d & ~wr_s;
  assign wake_fall = wake_d & ~wake_s;

  // port state
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  afbp_pkg::afbp_rd_state_t rd_st_reg;
  afbp_pkg::afbp_rd_state_t rd_st_next;
  afbp_pkg::afbp_byte_t rx_reg;
  afbp_pkg::afbp_byte_t rx_next;
  afbp_pkg::afbp_byte_t tx_reg;
  afbp_pkg::afbp_byte_t tx_next;
  afbp_pkg::afbp_byte_t bbrd_reg;
  afbp_pkg::afbp_byte_t bbrd_next;
  logic rx_ready_reg, rx_ready_next;
  logic [7:0] dout_reg, dout_next;
  logic [7:0] oe_reg, oe_next;
  logic avail_n_reg, avail_n_next;
  logic space_n_reg, space_n_next;
  logic flag_oe_reg, flag_oe_next;
  logic send_now_reg, send_now_next;
  logic resume_reg, resume_next;
  logic wstb_n_reg, wstb_n_next;
  logic rstb_n_reg, rstb_n_next;
  logic bb_pend_reg, bb_pend_next;

  logic fifo;
  logic bb;
  assign fifo = (mode_reg == afbp_pkg::MODE_FIFO);
  assign bb = mode_reg[1];

  always_comb begin
    mode_next = cfg_mode_i;
    rd_st_next = rd_st_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    send_now_next = 1'b0;
    resume_next = 1'b0;
    wstb_n_next = 1'b1;
    rstb_n_next = 1'b1;
    bb_pend_next = bb_pend_reg;
    bbrd_next.data = bbrd_reg.data;
    bbrd_next.valid = ~rstb_n_reg;
    // receive byte from usb engine into the holding slot
    if (rx_i.valid && rx_ready_reg) begin
      rx_next = rx_i;
    end
    // read strobe sequence
    case (rd_st_reg)
      afbp_pkg::RD_IDLE: begin
        if (fifo && rd_fall && rx_reg.valid) begin
          dout_next = rx_reg.data;
          oe_next = afbp_pkg::OE_ALL;
          rd_st_next = afbp_pkg::RD_HOLD;
        end else if (!bb) begin
          oe_next = afbp_pkg::OE_NONE;
        end
      end
      afbp_pkg::RD_HOLD: begin
        if (rd_s || !fifo) begin
          oe_next = afbp_pkg::OE_NONE;
          rx_next.valid = 1'b0;
          rd_st_next = afbp_pkg::RD_IDLE;
        end
      end
      default: begin
        oe_next = afbp_pkg::OE_NONE;
        rd_st_next = afbp_pkg::RD_IDLE;
      end
    endcase
    // transmit slot drains to the usb engine, fills on write strobe
    if (tx_reg.valid && tx_ready_i) begin
      tx_next.valid = 1'b0;
    end else if (fifo && wr_fall && !tx_reg.valid) begin
      tx_next.valid = 1'b1;
      tx_next.data = dat_s;
    end
    rx_ready_next = ~rx_next.valid;
    // receive flag low only with a byte waiting and no read in progress
    avail_n_next = ~(fifo & rx_next.valid & rd_s &
                     (rd_st_next == afbp_pkg::RD_IDLE));
    // transmit flag low only with an empty slot, high during a write
    space_n_next = ~(fifo & ~tx_next.valid & wr_s);
    flag_oe_next = fifo;
    // send immediate / wakeup
    if (mode_reg != afbp_pkg::MODE_OFF && wake_fall) begin
      if (usb_suspend_i) begin
        resume_next = cfg_wake_en_i;
      end else begin
        send_now_next = 1'b1;
      end
    end
    // bit-bang mode
    if (bb) begin
      oe_next = bb_dir_i;
      if (bb_wr_i.valid) begin
        dout_next = bb_wr_i.data;
        wstb_n_next = 1'b0;
        if (mode_reg == afbp_pkg::MODE_BB_SYNC) begin
          bb_pend_next = 1'b1;
        end
      end
      if (bb_rd_req_i && mode_reg == afbp_pkg::MODE_BB_ASYNC) begin
        bb_pend_next = 1'b1;
      end
      if (bb_pend_reg) begin
        bbrd_next.data = dat_s;
        rstb_n_next = 1'b0;
        bb_pend_next = 1'b0;
      end
    end else begin
      bb_pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_reg <= afbp_pkg::MODE_OFF;
      rd_st_reg <= afbp_pkg::RD_IDLE;
      rx_reg <= '0;
      tx_reg <= '0;
      bbrd_reg <= '0;
      rx_ready_reg <= 1'b0;
      dout_reg <= afbp_pkg::DATA_RST;
      oe_reg <= afbp_pkg::OE_NONE;
      avail_n_reg <= 1'b1;
      space_n_reg <= 1'b1;
      flag_oe_reg <= 1'b0;
      send_now_reg <= 1'b0;
      resume_reg <= 1'b0;
      wstb_n_reg <= 1'b1;
      rstb_n_reg <= 1'b1;
      bb_pend_reg <= 1'b0;
    end else if (ce_i) begin
      mode_reg <= mode_next;
      rd_st_reg <= rd_st_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      bbrd_reg <= bbrd_next;
      rx_ready_reg <= rx_ready_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      avail_n_reg <= avail_n_next;
      space_n_reg <= space_n_next;
      flag_oe_reg <= flag_oe_next;
      send_now_reg <= send_now_next;
      resume_reg <= resume_next;
      wstb_n_reg <= wstb_n_next;
      rstb_n_reg <= rstb_n_next;
      bb_pend_reg <= bb_pend_next;
    end
  end

  assign rx_ready_o = rx_ready_reg;
  assign tx_o = tx_reg;
  assign send_now_o = send_now_reg;
  assign resume_req_o = resume_reg;
  assign bb_rd_o = bbrd_reg;
  assign port_data_o = dout_reg;
  assign port_data_oe_o = oe_reg;
  assign rx_avail_n_o = avail_n_reg;
  assign rx_avail_n_oe_o = flag_oe_reg;
  assign tx_space_n_o = space_n_reg;
  assign tx_space_n_oe_o = flag_oe_reg;
  assign write_done_strobe_n_o = wstb_n_reg;
  assign read_done_strobe_n_o = rstb_n_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_mode_gate: assert property (
    ce_i && (mode_reg != afbp_pkg::MODE_FIFO) |=> !rx_avail_n_oe_o && !tx_space_n_oe_o)
    else $error("flags driven outside fifo mode");

  a_oe_rd_low: assert property (
    fifo && (port_data_oe_o != afbp_pkg::OE_NONE) |-> !$past(rd_s))
    else $error("bus driven without read strobe low");

  a_avail_byte: assert property (
    !rx_avail_n_o |-> rx_reg.valid && rx_avail_n_oe_o)
    else $error("receive flag low with no byte");

  a_avail_after_rd: assert property (
    ce_i && (rd_st_reg == afbp_pkg::RD_HOLD) && rd_s |=> rx_avail_n_o && !rx_reg.valid)
    else $error("receive flag not high after read");

  a_reset_float: assert property (
    @(posedge clk_i) disable iff (1'b0)
    srst_i |=> !rx_avail_n_oe_o && !tx_space_n_oe_o && (port_data_oe_o == afbp_pkg::OE_NONE))
    else $error("pins driven after reset");

  a_space_empty: assert property (
    !tx_space_n_o |-> !tx_reg.valid && wr_d)
    else $error("transmit flag low with slot full");

  a_read_data: assert property (
    ce_i && fifo && (rd_st_reg == afbp_pkg::RD_IDLE) && rd_fall && rx_reg.valid
    |=> (port_data_o == $past(rx_reg.data)) && (port_data_oe_o == afbp_pkg::OE_ALL)
        && (rd_st_reg == afbp_pkg::RD_HOLD))
    else $error("read byte not placed on bus");

  a_wr_capture: assert property (
    ce_i && fifo && wr_fall && !tx_reg.valid |=> tx_o.valid && (tx_o.data == $past(dat_s)))
    else $error("write byte not captured");

  a_resume: assert property (
    ce_i && fifo && wake_fall && usb_suspend_i && cfg_wake_en_i |=> resume_req_o && !send_now_o)
    else $error("resume not requested");

  a_send_now: assert property (
    ce_i && fifo && wake_fall && !usb_suspend_i |=> send_now_o && !resume_req_o)
    else $error("send immediate not raised");

  a_bb_write: assert property (
    ce_i && bb && bb_wr_i.valid
    |=> !write_done_strobe_n_o && (port_data_o == $past(bb_wr_i.data)))
    else $error("bit-bang write not strobed");

  a_bb_dir: assert property (
    ce_i && bb |=> (port_data_oe_o == $past(bb_dir_i)))
    else $error("bit-bang direction not applied");

  a_bb_read: assert property (
    ce_i && !read_done_strobe_n_o |=> read_done_strobe_n_o && bb_rd_o.valid)
    else $error("read-done edge missing");

  c_fifo_read: cover property (rd_st_reg == afbp_pkg::RD_HOLD ##[1:50] rx_avail_n_o);
  c_fifo_write: cover property (fifo && wr_fall && !tx_reg.valid);
  c_bb_read: cover property (!read_done_strobe_n_o ##1 bb_rd_o.valid);
  c_resume: cover property (resume_req_o);

endmodule : afbp_port

// ### tb/afbp_ext_model.sv
// external logic at the pins of one port channel: strobes, data, wakeup
// assumes the bench clock; flag pins pulled up when undriven
`timescale 1ns/1ps
module afbp_ext_model (
  // clock
  input wire logic clk_i,
  // device pins
  input wire logic [7:0] dev_data_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic rx_avail_n_i,
  input wire logic rx_oe_i,
  input wire logic tx_space_n_i,
  input wire logic tx_oe_i,
  // driven pins
  output logic rd_n_o,
  output logic wr_n_o,
  output logic wake_n_o,
  output logic [7:0] data_o
);
  logic [7:0] drv = 8'h00;
  logic drv_en = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] got;
  logic rx_flag;
  logic tx_flag;
  event got_ev;
  initial begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wake_n_o = 1'b1;
  end
  // released lines toggle each cycle
  assign data_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & (drv_en ? drv : ~last));
  assign rx_flag = rx_oe_i ? rx_avail_n_i : 1'b1;
  assign tx_flag = tx_oe_i ? tx_space_n_i : 1'b1;
  always @(posedge clk_i) last <= data_o;
  task automatic drive_lines(input logic [7:0] d, input logic en);
    drv <= d;
    drv_en <= en;
  endtask : drive_lines
  // honest=0 reads against a high flag on purpose
  task automatic read_byte(input bit honest);
    for (int n = 0; honest && rx_flag !== 1'b0 && n < 300; n++) @(negedge clk_i);
    @(posedge clk_i);
    rd_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    got = data_o;
    rd_n_o <= 1'b1;
    if (honest) ->got_ev;
    repeat (4) @(posedge clk_i);
  endtask : read_byte
  task automatic write_byte(input logic [7:0] d);
    for (int n = 0; tx_flag !== 1'b0 && n < 300; n++) @(negedge clk_i);
    @(posedge clk_i);
    drive_lines(d, 1'b1);
    repeat (3) @(posedge clk_i);
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    drv_en <= 1'b0;
  endtask : write_byte
  task automatic pulse_wake();
    wake_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wake_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : pulse_wake
endmodule : afbp_ext_model

// ### tb/async_fifo_bitbang_port_test.sv
// self-checking bench for one port channel in every mode
// assumes afbp_pkg and afbp_port compiled first
`timescale 1ns/1ps
module async_fifo_bitbang_port_test;
  logic clk_i, srst_i, cfg_wake_en_i, usb_suspend_i, tx_ready_i, bb_rd_req_i;
  logic [1:0] cfg_mode_i;
  logic [7:0] bb_dir_i, port_data_o, port_data_oe_o, data_w;
  afbp_pkg::afbp_byte_t rx_i, tx_o, bb_wr_i, bb_rd_o;
  logic rx_ready_o, send_now_o, resume_req_o, rd_n, wr_n, wake_n, ce;
  logic rx_avail_n_o, rx_avail_n_oe_o, tx_space_n_o, tx_space_n_oe_o;
  logic write_done_strobe_n_o, read_done_strobe_n_o;
  logic [8:0] exp_q[$];
  logic [7:0] d0, d1;
  int error_cnt = 0;
  int tests_run = 0;
  int seed;
  afbp_port i_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .cfg_mode_i(cfg_mode_i),
    .cfg_wake_en_i(cfg_wake_en_i), .usb_suspend_i(usb_suspend_i), .rx_i(rx_i),
    .rx_ready_o(rx_ready_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .send_now_o(send_now_o),
    .resume_req_o(resume_req_o), .bb_dir_i(bb_dir_i), .bb_wr_i(bb_wr_i),
    .bb_rd_req_i(bb_rd_req_i), .bb_rd_o(bb_rd_o), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .send_now_wakeup_n_i(wake_n), .port_data_i(data_w), .port_data_o(port_data_o),
    .port_data_oe_o(port_data_oe_o), .rx_avail_n_o(rx_avail_n_o),
    .rx_avail_n_oe_o(rx_avail_n_oe_o), .tx_space_n_o(tx_space_n_o),
    .tx_space_n_oe_o(tx_space_n_oe_o), .write_done_strobe_n_o(write_done_strobe_n_o),
    .read_done_strobe_n_o(read_done_strobe_n_o));
  afbp_ext_model i_ext (.clk_i(clk_i), .dev_data_i(port_data_o), .dev_oe_i(port_data_oe_o),
    .rx_avail_n_i(rx_avail_n_o), .rx_oe_i(rx_avail_n_oe_o), .tx_space_n_i(tx_space_n_o),
    .tx_oe_i(tx_space_n_oe_o), .rd_n_o(rd_n), .wr_n_o(wr_n), .wake_n_o(wake_n),
    .data_o(data_w));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic cmp(input string what, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic take(input string what, input logic [8:0] g);
    logic [8:0] e;
    e = 9'h1ff;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    cmp(what, e, g);
  endtask : take
  // results are taken off the queue as they appear
  always @(negedge clk_i) begin
    if (tx_o.valid === 1'b1 && tx_ready_i === 1'b1) take("tx byte", {1'b0, tx_o.data});
    if (bb_rd_o.valid === 1'b1) take("bb sample", {1'b0, bb_rd_o.data});
    if (write_done_strobe_n_o === 1'b0) take("bb write", {1'b0, port_data_o});
    if (send_now_o === 1'b1) take("send now", 9'h100);
    if (resume_req_o === 1'b1) take("resume", 9'h101);
  end
  always @(i_ext.got_ev) take("rx byte", {1'b0, i_ext.got});
  always @(posedge clk_i) tx_ready_i <= 1'($random(seed));
  task automatic do_reset(input logic [1:0] m);
    cfg_mode_i <= m;
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp("flag oe", 9'h0, {7'h0, rx_avail_n_oe_o, tx_space_n_oe_o});
    @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : do_reset
  task automatic refused_read();
    fork
      i_ext.read_byte(1'b0);
      begin
        repeat (6) @(negedge clk_i);
        cmp("refused oe", 9'h0, {1'b0, port_data_oe_o});
      end
    join
  endtask : refused_read
  task automatic usb_send(input logic [7:0] d);
    @(posedge clk_i);
    rx_i <= {1'b1, d};
    @(negedge clk_i);
    for (int n = 0; n < 300 && rx_ready_o !== 1'b1; n++) @(negedge clk_i);
    @(posedge clk_i);
    rx_i <= '0;
    @(negedge clk_i);
    cmp("rx ready", 9'h0, {8'h0, rx_ready_o});
  endtask : usb_send
  task automatic bb_write(input logic [7:0] d, input logic [7:0] dir, input bit sync_rd);
    bb_dir_i <= dir;
    bb_wr_i <= {1'b1, d};
    exp_q.push_back({1'b0, d});
    if (sync_rd) exp_q.push_back({1'b0, i_ext.drv});
    @(posedge clk_i);
    bb_wr_i <= '0;
    repeat (5) @(posedge clk_i);
    cmp("bb oe", {1'b0, dir}, {1'b0, port_data_oe_o});
  endtask : bb_write
  task automatic give_verdict();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    #(5000 * 100);
    error_cnt++;
    give_verdict();
  end
  initial begin
    seed = 75;
    srst_i = 1'b1;
    ce = 1'b1;
    cfg_mode_i = afbp_pkg::MODE_OFF;
    {cfg_wake_en_i, usb_suspend_i, bb_rd_req_i} = 3'h0;
    {rx_i, bb_wr_i, bb_dir_i} = '0;
    do_reset(afbp_pkg::MODE_OFF);
    refused_read();
    do_reset(afbp_pkg::MODE_FIFO);
    refused_read();
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    exp_q.push_back({1'b0, d0});
    exp_q.push_back({1'b0, d1});
    fork
      begin usb_send(d0); usb_send(d1); end
      begin i_ext.read_byte(1'b1); i_ext.read_byte(1'b1); end
    join
    repeat (3) @(negedge clk_i);
    cmp("rx flag", 9'h1, {8'h0, i_ext.rx_flag});
    cmp("idle oe", 9'h0, {1'b0, port_data_oe_o});
    for (int i = 0; i < 3; i++) begin
      d0 = 8'($random(seed));
      exp_q.push_back({1'b0, d0});
      i_ext.write_byte(d0);
    end
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    cmp("tx flag", 9'h0, {8'h0, i_ext.tx_flag});
    exp_q.push_back(9'h100);
    i_ext.pulse_wake();
    usb_suspend_i <= 1'b1;
    cfg_wake_en_i <= 1'b1;
    exp_q.push_back(9'h101);
    i_ext.pulse_wake();
    cfg_wake_en_i <= 1'b0;
    i_ext.pulse_wake();
    do_reset(afbp_pkg::MODE_BB_ASYNC);
    d0 = 8'($random(seed));
    bb_write(d0, 8'hff, 1'b0);
    bb_write(~d0, 8'h5a, 1'b0);
    // enable low: a host write must leave lines and strobe untouched
    ce <= 1'b0;
    bb_wr_i <= {1'b1, d0};
    @(posedge clk_i);
    bb_wr_i <= '0;
    repeat (3) @(posedge clk_i);
    cmp("frozen data", {1'b0, ~d0}, {1'b0, port_data_o});
    ce <= 1'b1;
    d1 = 8'($random(seed));
    i_ext.drive_lines(d1, 1'b1);
    bb_dir_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    exp_q.push_back({1'b0, d1});
    bb_rd_req_i <= 1'b1;
    @(posedge clk_i);
    bb_rd_req_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    cmp("rd strobe", 9'h0, {8'h0, read_done_strobe_n_o});
    repeat (5) @(posedge clk_i);
    do_reset(afbp_pkg::MODE_BB_SYNC);
    repeat (4) @(posedge clk_i);
    bb_write(d0, 8'h00, 1'b1);
    i_ext.drive_lines(d1, 1'b0);
    repeat (10) @(posedge clk_i);
    give_verdict();
  end
endmodule : async_fifo_bitbang_port_test
